/* File: logic/lvpm_ctrl.sv */
// low-voltage detect / warning and stop-mode control registers
// assumes comparators drive raw trips, power-on reset qualifies sys_rst
//
// Behaviour
// - enabled detect event sets sticky detect flag
// - writing detect ack one clears detect flag
// - interrupt enable requests interrupt while flag set
// - reset enable forces reset on detect flag
// - stop enable keeps detection alive in stop
// - detect enable gates detection and the reset request, not the interrupt from a set flag
// - bit zero drives reference buffer enable
// - protected control bits accept first write only
// - warning flag sets below warning trip level
// - warning flag stays set after warning ends
// - warning ack clears only when warning absent
// - bit five selects detect trip level
// - bit four selects warning trip level
// - trip selects clear only on power-on reset
// - wake from partial power-down sets flag
// - writing partial power-down ack clears flag
// - write-once bit selects stop variant
`timescale 1ns/100ps
module lvpm_ctrl
  import lvpm_pkg::*;
(
  input logic core_clk, // bus clock, 200 MHz
  input logic sys_rst, // synchronous reset, high
  input logic power_on_reset, // high with sys_rst on power-on
  input logic clk_en, // freezes all state when low
  input lvpm_bus_req_t bus_req, // register port request
  output logic [7:0] reg_rdata, // read data, cycle after read
  input lvpm_cmp_t cmp_raw, // analog comparator trips
  input logic in_stop, // device is in stop mode
  input logic ppd_wake, // pulse: woke from partial power-down
  output lvpm_ctrl_out_t ctrl_out, // analog and power controls
  output logic detect_flag, // low-voltage detect flag
  output logic detect_reset_req, // forces device reset
  output logic irq // level interrupt
);

  lvpm_state_t st;
  lvpm_state_t next_st;
  lvpm_cmp_t cmp_sync;
  logic warning_flag;
  logic partial_powerdown_flag;
  logic detect_live;
  logic detect_set;
  logic wr_det;
  logic wr_warn;
  logic detect_ack;
  logic warning_ack;
  logic partial_powerdown_ack;
  logic [2:0] events;
  logic [2:0] rd_clear;

  lvpm_sync2 u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .cmp_raw(cmp_raw),
    .cmp_sync(cmp_sync)
  );

  // detection live only when enabled, and in stop only if allowed
  assign detect_live = st.detect_enable && (!in_stop || st.detect_stop_enable);
  assign detect_set = detect_live && cmp_sync.detect_trip;

  assign wr_det = bus_req.wr && lvpm_hit(bus_req.addr, LVPM_OFF_DETECT);
  assign wr_warn = bus_req.wr && lvpm_hit(bus_req.addr, LVPM_OFF_WARN);
  assign detect_ack = wr_det && bus_req.wdata[LVPM_DET_ACK_BIT];
  // clear refused while the warning is still present
  assign warning_ack = wr_warn && bus_req.wdata[LVPM_WARN_ACK_BIT]
                       && !cmp_sync.warning_trip;
  assign partial_powerdown_ack = wr_warn && bus_req.wdata[LVPM_PPD_ACK_BIT];

  lvpm_sticky u_detect_flag (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set_evt(detect_set),
    .clr_req(detect_ack),
    .flag(detect_flag)
  );

  // level set: also catches a warning already present after reset
  lvpm_sticky u_warning_flag (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set_evt(cmp_sync.warning_trip),
    .clr_req(warning_ack),
    .flag(warning_flag)
  );

  lvpm_sticky u_ppd_flag (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set_evt(ppd_wake),
    .clr_req(partial_powerdown_ack),
    .flag(partial_powerdown_flag)
  );

  // interrupt events: each flag's set condition while that flag is still clear
  always_comb begin
    events = LVPM_EV_RST;
    events[LVPM_EV_DETECT_BIT] = detect_set && !detect_flag;
    events[LVPM_EV_WARN_BIT] = cmp_sync.warning_trip && !warning_flag;
    events[LVPM_EV_PPD_BIT] = ppd_wake && !partial_powerdown_flag;
  end

  assign rd_clear = (bus_req.rd && lvpm_hit(bus_req.addr, LVPM_OFF_IRQ_STAT)) ? 3'h7 : 3'h0;

  always_comb begin
    next_st = st;
    // read data stand only in the cycle after the read
    next_st.rdata = LVPM_DATA_RST;
    if (bus_req.rd) begin
      case (bus_req.addr)
        LVPM_OFF_DETECT: begin
          // ack bit and reserved bit read zero
          next_st.rdata[LVPM_DET_FLAG_BIT] = detect_flag;
          next_st.rdata[LVPM_DET_IRQ_EN_BIT] = st.detect_irq_enable;
          next_st.rdata[LVPM_DET_RST_EN_BIT] = st.detect_reset_enable;
          next_st.rdata[LVPM_DET_STOP_EN_BIT] = st.detect_stop_enable;
          next_st.rdata[LVPM_DET_EN_BIT] = st.detect_enable;
          next_st.rdata[LVPM_REF_BUF_BIT] = st.reference_buffer_enable;
        end
        LVPM_OFF_WARN: begin
          next_st.rdata[LVPM_WARN_FLAG_BIT] = warning_flag;
          next_st.rdata[LVPM_DET_TRIP_BIT] = st.detect_trip_select;
          next_st.rdata[LVPM_WARN_TRIP_BIT] = st.warning_trip_select;
          next_st.rdata[LVPM_PPD_FLAG_BIT] = partial_powerdown_flag;
          next_st.rdata[LVPM_STOP_VAR_BIT] = st.stop_variant_select;
        end
        LVPM_OFF_IRQ_STAT: begin
          next_st.rdata[2:0] = st.irq_status;
        end
        LVPM_OFF_IRQ_MASK: begin
          next_st.rdata[2:0] = st.irq_mask;
        end
        default: begin
          next_st.rdata = LVPM_DATA_RST;
        end
      endcase
    end
    if (wr_det) begin
      next_st.detect_irq_enable = bus_req.wdata[LVPM_DET_IRQ_EN_BIT];
      next_st.reference_buffer_enable = bus_req.wdata[LVPM_REF_BUF_BIT];
      // reserved bit is not stored, software keeps it zero
      if (!st.detect_ctrl_written) begin
        next_st.detect_reset_enable = bus_req.wdata[LVPM_DET_RST_EN_BIT];
        next_st.detect_stop_enable = bus_req.wdata[LVPM_DET_STOP_EN_BIT];
        next_st.detect_enable = bus_req.wdata[LVPM_DET_EN_BIT];
        next_st.detect_ctrl_written = 1'b1;
      end
    end
    if (wr_warn) begin
      next_st.detect_trip_select = bus_req.wdata[LVPM_DET_TRIP_BIT];
      next_st.warning_trip_select = bus_req.wdata[LVPM_WARN_TRIP_BIT];
      if (!st.stop_ctrl_written) begin
        next_st.stop_variant_select = bus_req.wdata[LVPM_STOP_VAR_BIT];
        next_st.stop_ctrl_written = 1'b1;
      end
    end
    if (bus_req.wr && lvpm_hit(bus_req.addr, LVPM_OFF_IRQ_MASK)) begin
      next_st.irq_mask = bus_req.wdata[2:0];
    end
    // event wins over read-clear
    next_st.irq_status = (st.irq_status & ~rd_clear) | events;
    if (sys_rst) begin
      next_st.detect_irq_enable = LVPM_DET_IRQ_EN_RST;
      next_st.detect_reset_enable = LVPM_DET_RST_EN_RST;
      next_st.detect_stop_enable = LVPM_DET_STOP_EN_RST;
      next_st.detect_enable = LVPM_DET_EN_RST;
      next_st.reference_buffer_enable = LVPM_REF_BUF_RST;
      next_st.detect_ctrl_written = 1'b0;
      next_st.stop_variant_select = LVPM_STOP_VAR_RST;
      next_st.stop_ctrl_written = 1'b0;
      next_st.irq_status = LVPM_EV_RST;
      next_st.irq_mask = LVPM_EV_RST;
      next_st.rdata = LVPM_DATA_RST;
      // trip selects survive all but power-on reset
      next_st.detect_trip_select = power_on_reset ? LVPM_TRIP_SEL_POR
                                                  : st.detect_trip_select;
      next_st.warning_trip_select = power_on_reset ? LVPM_TRIP_SEL_POR
                                                   : st.warning_trip_select;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign detect_reset_req = st.detect_reset_enable && st.detect_enable && detect_flag;
  assign irq = (st.detect_irq_enable && detect_flag)
               || |(st.irq_status & st.irq_mask);

  always_comb begin
    ctrl_out.detect_active = detect_live;
    ctrl_out.detect_trip_select = st.detect_trip_select;
    ctrl_out.warning_trip_select = st.warning_trip_select;
    ctrl_out.reference_buffer_enable = st.reference_buffer_enable;
    ctrl_out.stop_variant_select = st.stop_variant_select;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_detect_set;
    clk_en && detect_set |=> detect_flag;
  endproperty
  a_detect_set: assert property (p_detect_set) else $error("detect flag not set");

  property p_detect_ack;
    clk_en && detect_ack && !detect_set |=> !detect_flag;
  endproperty
  a_detect_ack: assert property (p_detect_ack) else $error("detect ack failed");

  property p_detect_irq;
    clk_en && detect_set && st.detect_irq_enable && !wr_det |=> irq;
  endproperty
  a_detect_irq: assert property (p_detect_irq) else $error("detect irq missing");

  property p_detect_reset;
    clk_en && detect_set && st.detect_reset_enable && !wr_det |=> detect_reset_req;
  endproperty
  a_detect_reset: assert property (p_detect_reset) else $error("reset not forced");

  property p_stop_gate;
    clk_en && in_stop && !st.detect_stop_enable && !detect_flag |=> !detect_flag;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("detect set in stop");

  property p_disabled;
    clk_en && !st.detect_enable && !detect_flag |=> !detect_flag;
  endproperty
  a_disabled: assert property (p_disabled) else $error("detect set while off");

  property p_write_once;
    clk_en && wr_det && st.detect_ctrl_written |=>
      $stable(st.detect_enable) && $stable(st.detect_reset_enable)
      && $stable(st.detect_stop_enable);
  endproperty
  a_write_once: assert property (p_write_once) else $error("second write taken");

  property p_warn_set;
    clk_en && cmp_sync.warning_trip |=> warning_flag;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning flag not set");

  property p_warn_hold;
    warning_flag && cmp_sync.warning_trip |=> warning_flag;
  endproperty
  a_warn_hold: assert property (p_warn_hold) else $error("warning cleared early");

  property p_ppd_set;
    clk_en && ppd_wake |=> partial_powerdown_flag;
  endproperty
  a_ppd_set: assert property (p_ppd_set) else $error("ppd flag not set");

  property p_stop_once;
    clk_en && wr_warn && st.stop_ctrl_written |=> $stable(st.stop_variant_select);
  endproperty
  a_stop_once: assert property (p_stop_once) else $error("stop variant rewritten");

  property p_trip_keep;
    @(posedge core_clk) disable iff (1'b0)
    sys_rst && !power_on_reset |=> $stable(st.detect_trip_select)
      && $stable(st.warning_trip_select);
  endproperty
  a_trip_keep: assert property (p_trip_keep) else $error("trip select lost");

  property p_trip_por;
    @(posedge core_clk) disable iff (1'b0)
    sys_rst && power_on_reset |=> !st.detect_trip_select
      && !st.warning_trip_select;
  endproperty
  a_trip_por: assert property (p_trip_por) else $error("trip select kept on por");

  property p_warn_ack;
    clk_en && warning_ack |=> !warning_flag;
  endproperty
  a_warn_ack: assert property (p_warn_ack) else $error("warning ack failed");

  property p_ppd_ack;
    clk_en && partial_powerdown_ack && !ppd_wake |=> !partial_powerdown_flag;
  endproperty
  a_ppd_ack: assert property (p_ppd_ack) else $error("ppd ack failed");

  property p_ref_buf_on;
    clk_en && wr_det && bus_req.wdata[LVPM_REF_BUF_BIT] |=> ctrl_out.reference_buffer_enable;
  endproperty
  a_ref_buf_on: assert property (p_ref_buf_on) else $error("ref buffer not on");

  property p_ref_buf_off;
    clk_en && wr_det && !bus_req.wdata[LVPM_REF_BUF_BIT] |=> !ctrl_out.reference_buffer_enable;
  endproperty
  a_ref_buf_off: assert property (p_ref_buf_off) else $error("ref buffer not off");

  property p_det_trip_sel;
    clk_en && wr_warn && bus_req.wdata[LVPM_DET_TRIP_BIT] |=> ctrl_out.detect_trip_select;
  endproperty
  a_det_trip_sel: assert property (p_det_trip_sel) else $error("detect trip sel lost");

  property p_warn_trip_sel;
    clk_en && wr_warn && bus_req.wdata[LVPM_WARN_TRIP_BIT] |=> ctrl_out.warning_trip_select;
  endproperty
  a_warn_trip_sel: assert property (p_warn_trip_sel) else $error("warn trip sel lost");

  property p_det_ack_rd;
    clk_en && bus_req.rd && lvpm_hit(bus_req.addr, LVPM_OFF_DETECT) |=> !reg_rdata[LVPM_DET_ACK_BIT];
  endproperty
  a_det_ack_rd: assert property (p_det_ack_rd) else $error("detect ack reads one");

  property p_warn_ack_rd;
    clk_en && bus_req.rd && lvpm_hit(bus_req.addr, LVPM_OFF_WARN) |=>
      !reg_rdata[LVPM_WARN_ACK_BIT] && !reg_rdata[LVPM_PPD_ACK_BIT];
  endproperty
  a_warn_ack_rd: assert property (p_warn_ack_rd) else $error("ack bit reads one");

  property p_ppd_event;
    clk_en && ppd_wake && !partial_powerdown_flag |=> st.irq_status[LVPM_EV_PPD_BIT];
  endproperty
  a_ppd_event: assert property (p_ppd_event) else $error("ppd event lost");

  property p_warn_event;
    clk_en && cmp_sync.warning_trip && !warning_flag |=> st.irq_status[LVPM_EV_WARN_BIT];
  endproperty
  a_warn_event: assert property (p_warn_event) else $error("warning event lost");

  property p_stop_var;
    clk_en && wr_warn && !st.stop_ctrl_written && bus_req.wdata[LVPM_STOP_VAR_BIT]
      |=> ctrl_out.stop_variant_select;
  endproperty
  a_stop_var: assert property (p_stop_var) else $error("stop variant not taken");

  c_detect_irq: cover property (clk_en && detect_set ##1 irq);
  c_warn_ack: cover property (warning_flag && warning_ack && clk_en ##1 !warning_flag);
  c_stop_once: cover property (clk_en && wr_warn && st.stop_ctrl_written);
  c_ppd_irq: cover property (clk_en && ppd_wake ##1 irq);
  c_detect_reset: cover property (clk_en && detect_set && st.detect_reset_enable ##1 detect_reset_req);

endmodule

/* File: logic/lvpm_pkg.sv */
// package for the low-voltage and power-mode control block
// assumes one clock domain, synchronous active-high reset, byte-wide registers
package lvpm_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] LVPM_OFF_DETECT = 8'h00;
  localparam logic [7:0] LVPM_OFF_WARN = 8'h01;
  localparam logic [7:0] LVPM_OFF_IRQ_STAT = 8'h02;
  localparam logic [7:0] LVPM_OFF_IRQ_MASK = 8'h03;

  // low_voltage_detect_control fields
  localparam int unsigned LVPM_DET_FLAG_BIT = 7;
  localparam int unsigned LVPM_DET_ACK_BIT = 6;
  localparam int unsigned LVPM_DET_IRQ_EN_BIT = 5;
  localparam int unsigned LVPM_DET_RST_EN_BIT = 4;
  localparam int unsigned LVPM_DET_STOP_EN_BIT = 3;
  localparam int unsigned LVPM_DET_EN_BIT = 2;
  localparam int unsigned LVPM_REF_BUF_BIT = 0;

  // warning_and_stop_mode_control fields
  localparam int unsigned LVPM_WARN_FLAG_BIT = 7;
  localparam int unsigned LVPM_WARN_ACK_BIT = 6;
  localparam int unsigned LVPM_DET_TRIP_BIT = 5;
  localparam int unsigned LVPM_WARN_TRIP_BIT = 4;
  localparam int unsigned LVPM_PPD_FLAG_BIT = 3;
  localparam int unsigned LVPM_PPD_ACK_BIT = 2;
  localparam int unsigned LVPM_STOP_VAR_BIT = 0;

  // interrupt status / mask fields
  localparam int unsigned LVPM_EV_DETECT_BIT = 0;
  localparam int unsigned LVPM_EV_WARN_BIT = 1;
  localparam int unsigned LVPM_EV_PPD_BIT = 2;
  localparam int unsigned LVPM_EV_COUNT = 3;

  // values after reset
  localparam logic LVPM_DET_IRQ_EN_RST = 1'b0;
  localparam logic LVPM_DET_RST_EN_RST = 1'b1;
  localparam logic LVPM_DET_STOP_EN_RST = 1'b1;
  localparam logic LVPM_DET_EN_RST = 1'b1;
  localparam logic LVPM_REF_BUF_RST = 1'b0;
  localparam logic LVPM_TRIP_SEL_POR = 1'b0;
  localparam logic LVPM_STOP_VAR_RST = 1'b0;
  localparam logic [2:0] LVPM_EV_RST = 3'h0;
  localparam logic [7:0] LVPM_DATA_RST = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lvpm_bus_req_t;

  typedef struct packed {
    logic detect_trip;
    logic warning_trip;
  } lvpm_cmp_t;

  typedef struct packed {
    logic detect_active;
    logic detect_trip_select;
    logic warning_trip_select;
    logic reference_buffer_enable;
    logic stop_variant_select;
  } lvpm_ctrl_out_t;

  typedef struct packed {
    lvpm_cmp_t meta;
    lvpm_cmp_t sync;
  } lvpm_sync_state_t;

  typedef struct packed {
    logic flag;
  } lvpm_sticky_state_t;

  typedef struct packed {
    logic detect_irq_enable;
    logic detect_reset_enable;
    logic detect_stop_enable;
    logic detect_enable;
    logic reference_buffer_enable;
    logic detect_ctrl_written;
    logic detect_trip_select;
    logic warning_trip_select;
    logic stop_variant_select;
    logic stop_ctrl_written;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
  } lvpm_state_t;

  function automatic logic lvpm_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

endpackage

/* File: logic/lvpm_sticky.sv */
// sticky flag, set has priority over clear
// assumes set and clear are synchronous terms, set may be a held level
`timescale 1ns/100ps
module lvpm_sticky
  import lvpm_pkg::*;
(
  input logic core_clk, // bus clock
  input logic sys_rst, // synchronous reset, high
  input logic clk_en, // freezes state when low
  input logic set_evt, // set request
  input logic clr_req, // clear request
  output logic flag // current flag
);

  lvpm_sticky_state_t st;
  lvpm_sticky_state_t next_st;

  always_comb begin
    next_st = st;
    if (set_evt) begin
      next_st.flag = 1'b1;
    end else if (clr_req) begin
      next_st.flag = 1'b0;
    end
    if (sys_rst) begin
      next_st.flag = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || clk_en) begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

endmodule

/* File: logic/lvpm_sync2.sv */
// two-stage synchroniser for the analog comparator trip indications
// assumes raw inputs are asynchronous to core_clk
`timescale 1ns/100ps
module lvpm_sync2
  import lvpm_pkg::*;
(
  input logic core_clk, // bus clock
  input logic sys_rst, // synchronous reset, high
  input logic clk_en, // freezes state when low
  input lvpm_cmp_t cmp_raw, // comparator outputs, asynchronous
  output lvpm_cmp_t cmp_sync // synchronised trips
);

  lvpm_sync_state_t st;
  lvpm_sync_state_t next_st;

  // meta stage is read only by the sync stage
  always_comb begin
    next_st.meta = cmp_raw;
    next_st.sync = st.meta;
    if (sys_rst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || clk_en) begin
      st <= next_st;
    end
  end

  assign cmp_sync = st.sync;

endmodule

/* File: sim/tb_top.sv */
// self-checking bench for lvpm_ctrl, driven through its plain register port
// assumes the design's own embedded assertions; clock enable held high throughout
`timescale 1ns/100ps
module tb_top;
  import lvpm_pkg::*;

  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_on_reset = 1'b1;
  logic clk_en = 1'b1;
  logic in_stop = 1'b0;
  logic ppd_wake = 1'b0;
  lvpm_bus_req_t bus_req = '0;
  lvpm_cmp_t cmp_raw = '0;
  logic [7:0] reg_rdata;
  lvpm_ctrl_out_t ctrl_out;
  logic detect_flag;
  logic detect_reset_req;
  logic irq;
  int num_errors = 0;
  int checks_done = 0;

  always #2.5 core_clk = ~core_clk;

  lvpm_ctrl lvpm_ctrl_i (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .power_on_reset(power_on_reset),
    .clk_en(clk_en),
    .bus_req(bus_req),
    .reg_rdata(reg_rdata),
    .cmp_raw(cmp_raw),
    .in_stop(in_stop),
    .ppd_wake(ppd_wake),
    .ctrl_out(ctrl_out),
    .detect_flag(detect_flag),
    .detect_reset_req(detect_reset_req),
    .irq(irq)
  );

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // hold reset 20 cycles; por selects power-on reset
  task automatic do_rst(input logic por);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    power_on_reset <= por;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    power_on_reset <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask

  task automatic wait_det();
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      #1;
      if (detect_flag === 1'b1) begin
        return;
      end
    end
    num_errors++;
    $display("CHECK FAILED t=%0t detect flag never set", $time);
    end_sim();
  endtask

  task automatic ppd_pulse();
    @(posedge core_clk);
    ppd_wake <= 1'b1;
    @(posedge core_clk);
    ppd_wake <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  initial begin
    do_rst(1'b1);
    rd(LVPM_OFF_DETECT, 8'h1C, "detect reset value");
    rd(LVPM_OFF_WARN, 8'h00, "warn reset value");
    rd(LVPM_OFF_IRQ_STAT, 8'h00, "status reset");
    rd(LVPM_OFF_IRQ_MASK, 8'h00, "mask reset");
    rd(8'h04, 8'h00, "unmapped read");
    chk(8'(irq), 8'h00, "irq after reset");
    $display("test reset_values done");

    wr(LVPM_OFF_DETECT, 8'h21);
    rd(LVPM_OFF_DETECT, 8'h21, "first write");
    chk(8'(ctrl_out.reference_buffer_enable), 8'h01, "ref buffer on");
    wr(LVPM_OFF_DETECT, 8'h1C);
    rd(LVPM_OFF_DETECT, 8'h00, "locked bits");
    chk(8'(ctrl_out.reference_buffer_enable), 8'h00, "ref buffer off");
    @(posedge core_clk);
    cmp_raw.detect_trip <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk(8'(detect_flag), 8'h00, "flag while disabled");
    chk(8'(detect_reset_req), 8'h00, "reset while disabled");
    chk(8'(ctrl_out.detect_active), 8'h00, "active while disabled");
    @(posedge core_clk);
    cmp_raw.detect_trip <= 1'b0;
    $display("test write_once_detect done");

    do_rst(1'b0);
    wr(LVPM_OFF_DETECT, 8'h3C);
    cmp_raw.detect_trip <= 1'b1;
    wait_det();
    chk(8'(detect_reset_req), 8'h01, "reset request");
    chk(8'(irq), 8'h01, "detect irq");
    rd(LVPM_OFF_DETECT, 8'hBC, "flag read");
    rd(LVPM_OFF_IRQ_STAT, 8'h01, "detect event");
    rd(LVPM_OFF_IRQ_STAT, 8'h00, "status read clears");
    @(posedge core_clk);
    cmp_raw.detect_trip <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr(LVPM_OFF_DETECT, 8'h1C);
    rd(LVPM_OFF_DETECT, 8'h9C, "ack zero, flag kept");
    chk(8'(irq), 8'h00, "polling mode");
    wr(LVPM_OFF_DETECT, 8'h5C);
    rd(LVPM_OFF_DETECT, 8'h1C, "ack clears");
    chk(8'(detect_reset_req), 8'h00, "reset request off");
    $display("test detect_flag done");

    do_rst(1'b0);
    wr(LVPM_OFF_DETECT, 8'h14);
    in_stop <= 1'b1;
    cmp_raw.detect_trip <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk(8'(ctrl_out.detect_active), 8'h00, "off in stop");
    chk(8'(detect_flag), 8'h00, "no flag in stop");
    @(posedge core_clk);
    in_stop <= 1'b0;
    wait_det();
    @(posedge core_clk);
    cmp_raw.detect_trip <= 1'b0;
    wr(LVPM_OFF_WARN, 8'h31);
    rd(LVPM_OFF_WARN, 8'h31, "selects written");
    chk(8'(ctrl_out.detect_trip_select), 8'h01, "detect trip sel");
    chk(8'(ctrl_out.warning_trip_select), 8'h01, "warn trip sel");
    chk(8'(ctrl_out.stop_variant_select), 8'h01, "stop variant");
    wr(LVPM_OFF_WARN, 8'h00);
    rd(LVPM_OFF_WARN, 8'h01, "stop variant locked");
    wr(LVPM_OFF_WARN, 8'h30);
    do_rst(1'b0);
    rd(LVPM_OFF_WARN, 8'h30, "selects kept");
    do_rst(1'b1);
    rd(LVPM_OFF_WARN, 8'h00, "selects cleared by por");
    $display("test stop_and_selects done");

    @(posedge core_clk);
    cmp_raw.warning_trip <= 1'b1;
    do_rst(1'b0);
    repeat (4) @(posedge core_clk);
    rd(LVPM_OFF_WARN, 8'h80, "warn after reset");
    rd(LVPM_OFF_IRQ_STAT, 8'h02, "warn event");
    wr(LVPM_OFF_WARN, 8'h40);
    rd(LVPM_OFF_WARN, 8'h80, "ack while present");
    @(posedge core_clk);
    cmp_raw.warning_trip <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(LVPM_OFF_WARN, 8'h80, "warn sticky");
    wr(LVPM_OFF_WARN, 8'h40);
    rd(LVPM_OFF_WARN, 8'h00, "warn ack");
    @(posedge core_clk);
    cmp_raw.warning_trip <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(LVPM_OFF_WARN, 8'h80, "warn on trip");
    @(posedge core_clk);
    cmp_raw.warning_trip <= 1'b0;
    $display("test warning done");

    do_rst(1'b0);
    wr(LVPM_OFF_IRQ_MASK, 8'h04);
    ppd_pulse();
    chk(8'(irq), 8'h01, "ppd irq");
    rd(LVPM_OFF_WARN, 8'h08, "ppd flag");
    rd(LVPM_OFF_IRQ_STAT, 8'h04, "ppd event");
    @(posedge core_clk);
    #1;
    chk(8'(irq), 8'h00, "irq after status read");
    wr(LVPM_OFF_WARN, 8'h04);
    rd(LVPM_OFF_WARN, 8'h00, "ppd ack");
    wr(LVPM_OFF_IRQ_MASK, 8'h00);
    ppd_pulse();
    chk(8'(irq), 8'h00, "masked ppd irq");
    rd(LVPM_OFF_WARN, 8'h08, "ppd flag again");
    $display("test ppd_irq done");
    end_sim();
  end
endmodule
